// file: hw/fls_pkg.sv
// constants, layout codes and register map of the fp operand lane select block
// assumes a single 40 MHz clock and an apb slave port with 32-bit data
package fls_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int BUS_W       = 72;
  localparam int OPND_W      = 24;
  localparam int HALF_W      = 16;
  localparam int LOW_CODE_W  = 5;
  localparam int HIGH_CODE_W = 6;
  localparam int OFF_W       = 7;
  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 32;

  ////////////////////////////////////////////////////////////////////////////
  // lane-select codes
  localparam logic [LOW_CODE_W-1:0]  LO_BF16_SINGLE = 5'h13;
  localparam logic [LOW_CODE_W-1:0]  LO_BF16_DUAL   = 5'h14;
  localparam logic [LOW_CODE_W-1:0]  LO_BF16_ALT    = 5'h15;
  localparam logic [LOW_CODE_W-1:0]  LO_FP16_SINGLE = 5'h16;
  localparam logic [LOW_CODE_W-1:0]  LO_FP16_DUAL   = 5'h17;
  localparam logic [LOW_CODE_W-1:0]  LO_FP16_ALT    = 5'h18;
  localparam logic [LOW_CODE_W-1:0]  LO_FP24_SINGLE = 5'h19;
  localparam logic [LOW_CODE_W-1:0]  LO_FP24_DUAL   = 5'h1A;
  localparam logic [HIGH_CODE_W-1:0] HI_BF16_SINGLE = 6'h13;
  localparam logic [HIGH_CODE_W-1:0] HI_BF16_DUAL   = 6'h14;
  localparam logic [HIGH_CODE_W-1:0] HI_BF16_ALT    = 6'h15;
  localparam logic [HIGH_CODE_W-1:0] HI_FP16_SINGLE = 6'h16;
  localparam logic [HIGH_CODE_W-1:0] HI_FP16_DUAL   = 6'h17;
  localparam logic [HIGH_CODE_W-1:0] HI_FP16_ALT    = 6'h18;
  localparam logic [HIGH_CODE_W-1:0] HI_FP24_SINGLE = 6'h19;
  localparam logic [HIGH_CODE_W-1:0] HI_FP24_DUAL   = 6'h1A;
  localparam logic [HIGH_CODE_W-1:0] HI_BF16_SPLIT  = 6'h33;
  localparam logic [HIGH_CODE_W-1:0] HI_BF16_CMPCT  = 6'h35;
  localparam logic [HIGH_CODE_W-1:0] HI_FP16_SPLIT  = 6'h36;
  localparam logic [HIGH_CODE_W-1:0] HI_FP16_CMPCT  = 6'h38;
  localparam logic [HIGH_CODE_W-1:0] HI_FP24_SPLIT  = 6'h39;
  localparam logic [HIGH_CODE_W-1:0] HI_FP24_CMPCT  = 6'h3A;

  ////////////////////////////////////////////////////////////////////////////
  // operand layouts
  typedef enum logic [14:0] {
    LAY_NONE        = 15'h0001,
    LAY_BF16_SINGLE = 15'h0002,
    LAY_BF16_SPLIT  = 15'h0004,
    LAY_BF16_DUAL   = 15'h0008,
    LAY_BF16_ALT    = 15'h0010,
    LAY_BF16_CMPCT  = 15'h0020,
    LAY_FP16_SINGLE = 15'h0040,
    LAY_FP16_SPLIT  = 15'h0080,
    LAY_FP16_DUAL   = 15'h0100,
    LAY_FP16_ALT    = 15'h0200,
    LAY_FP16_CMPCT  = 15'h0400,
    LAY_FP24_SINGLE = 15'h0800,
    LAY_FP24_SPLIT  = 15'h1000,
    LAY_FP24_DUAL   = 15'h2000,
    LAY_FP24_CMPCT  = 15'h4000
  } fls_layout_type;

  // number formats reported in status
  localparam logic [1:0] FMT_NONE = 2'h0;
  localparam logic [1:0] FMT_BF16 = 2'h1;
  localparam logic [1:0] FMT_FP16 = 2'h2;
  localparam logic [1:0] FMT_FP24 = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // lane bit offsets
  localparam logic [OFF_W-1:0] OFF_0  = 7'h00;
  localparam logic [OFF_W-1:0] OFF_16 = 7'h10;
  localparam logic [OFF_W-1:0] OFF_24 = 7'h18;
  localparam logic [OFF_W-1:0] OFF_32 = 7'h20;
  localparam logic [OFF_W-1:0] OFF_48 = 7'h30;

  // the value 1.0 in each format
  localparam logic [OPND_W-1:0] ONE_BF16 = 24'h003F80;
  localparam logic [OPND_W-1:0] ONE_FP16 = 24'h003C00;
  localparam logic [OPND_W-1:0] ONE_FP24 = 24'h3F8000;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [ADDR_W-1:0] REG_CTRL   = 12'h000;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] REG_OPND_A = 12'h008;
  localparam logic [ADDR_W-1:0] REG_OPND_B = 12'h00C;
  localparam logic [ADDR_W-1:0] REG_OPND_C = 12'h010;
  localparam logic [ADDR_W-1:0] REG_OPND_D = 12'h014;

  localparam int CTRL_LOW_LSB    = 0;
  localparam int CTRL_HIGH_LSB   = 8;
  localparam int CTRL_SUM_BIT    = 16;
  localparam int CTRL_EXPW1_BIT  = 20;
  localparam int CTRL_EXPW2_BIT  = 21;
  localparam logic [DATA_W-1:0] CTRL_USED  = 32'h00313F1F;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000000;

  localparam int STAT_VALID_BIT  = 0;
  localparam int STAT_THREE_BIT  = 1;
  localparam int STAT_MISM_BIT   = 2;
  localparam int STAT_FMT_LSB    = 4;

endpackage

// file: hw/fls_cfg_if.sv
// carries lane-select codes to the layout decoder and the decoded layout back
// assumes both ends sit in the same clock domain; purely combinational
`timescale 1ns/1ps
interface fls_cfg_if;
  import fls_pkg::*;
  logic [LOW_CODE_W-1:0]  lowCode;
  logic [HIGH_CODE_W-1:0] highCode;
  fls_layout_type         layout;
  logic                   wideLanes;
  logic                   threeOperand;
  logic                   needExp8;
  logic [1:0]             format;

  modport decoder (input lowCode, input highCode, output layout, output wideLanes,
                   output threeOperand, output needExp8, output format);
  modport user    (output lowCode, output highCode, input layout, input wideLanes,
                   input threeOperand, input needExp8, input format);
endinterface

// file: hw/fls_layout_decode.sv
// turns the low and high lane-select codes into one operand layout
// assumes codes are static while operands flow; unknown pairs give LAY_NONE
`timescale 1ns/1ps
module fls_layout_decode
  import fls_pkg::*;
(
  // configuration link
  fls_cfg_if.decoder cfg
);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cfg.layout = LAY_NONE;
    unique case (cfg.lowCode)
      LO_BF16_SINGLE: begin
        if (cfg.highCode == HI_BF16_SINGLE) cfg.layout = LAY_BF16_SINGLE; // [RULE3]
        if (cfg.highCode == HI_BF16_SPLIT)  cfg.layout = LAY_BF16_SPLIT;  // [RULE4]
      end
      LO_BF16_DUAL: begin
        if (cfg.highCode == HI_BF16_DUAL)   cfg.layout = LAY_BF16_DUAL;   // [RULE5]
      end
      LO_BF16_ALT: begin
        if (cfg.highCode == HI_BF16_ALT)    cfg.layout = LAY_BF16_ALT;    // [RULE6]
        if (cfg.highCode == HI_BF16_CMPCT)  cfg.layout = LAY_BF16_CMPCT;  // [RULE7]
      end
      LO_FP16_SINGLE: begin
        if (cfg.highCode == HI_FP16_SINGLE) cfg.layout = LAY_FP16_SINGLE; // [RULE8]
        if (cfg.highCode == HI_FP16_SPLIT)  cfg.layout = LAY_FP16_SPLIT;  // [RULE9]
      end
      LO_FP16_DUAL: begin
        if (cfg.highCode == HI_FP16_DUAL)   cfg.layout = LAY_FP16_DUAL;   // [RULE10]
      end
      LO_FP16_ALT: begin
        if (cfg.highCode == HI_FP16_ALT)    cfg.layout = LAY_FP16_ALT;    // [RULE11]
        if (cfg.highCode == HI_FP16_CMPCT)  cfg.layout = LAY_FP16_CMPCT;  // [RULE12]
      end
      LO_FP24_SINGLE: begin
        if (cfg.highCode == HI_FP24_SINGLE) cfg.layout = LAY_FP24_SINGLE; // [RULE13]
        if (cfg.highCode == HI_FP24_SPLIT)  cfg.layout = LAY_FP24_SPLIT;  // [RULE14]
      end
      LO_FP24_DUAL: begin
        if (cfg.highCode == HI_FP24_DUAL)   cfg.layout = LAY_FP24_DUAL;   // [RULE15]
        if (cfg.highCode == HI_FP24_CMPCT)  cfg.layout = LAY_FP24_CMPCT;  // [RULE16]
      end
      default: cfg.layout = LAY_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // format attributes of the layout
  assign cfg.threeOperand = cfg.layout inside {LAY_BF16_SINGLE, LAY_FP16_SINGLE, LAY_FP24_SINGLE};
  assign cfg.wideLanes    = cfg.layout inside {LAY_FP24_SINGLE, LAY_FP24_SPLIT, LAY_FP24_DUAL, LAY_FP24_CMPCT};
  assign cfg.format       = (cfg.layout == LAY_NONE) ? FMT_NONE :
                            cfg.wideLanes ? FMT_FP24 :
                            (cfg.layout inside {LAY_FP16_SINGLE, LAY_FP16_SPLIT, LAY_FP16_DUAL, LAY_FP16_ALT,
                                                LAY_FP16_CMPCT}) ? FMT_FP16 : FMT_BF16;
  assign cfg.needExp8     = (cfg.format != FMT_FP16);

endmodule

// file: hw/fls_lane_select.sv
// top of the fp operand lane select: apb config, operand muxing, result select
// assumes operand buses and product inputs are synchronous to ref_clk
`timescale 1ns/1ps

// How it works
// RULE1 - a,b feed first product, c,d second
// RULE2 - three-operand layouts force d to 1.0
// RULE3 - bf16 single: a[15:0], b[31:16], c[47:32]
// RULE4 - bf16 split: a,c low lane; b,d second
// RULE5 - bf16 dual: d from second high [63:48]
// RULE6 - bf16 alternate: a,b lane0; c,d lane1
// RULE7 - bf16 compact: all operands from [15:0]
// RULE8 - fp16 single: a,b,c like bf16 single
// RULE9 - fp16 split: a,c lane0; b,d lane1
// RULE10 - fp16 dual: c[47:32], d[63:48]
// RULE11 - fp16 alternate: a,b lane0; c,d lane1
// RULE12 - fp16 compact: all operands from [15:0]
// RULE13 - fp24 single: a[23:0], b[47:24], c[71:48]
// RULE14 - fp24 split: a,c [23:0]; b,d [47:24]
// RULE15 - fp24 dual: a,b [23:0]; c,d [47:24]
// RULE16 - fp24 compact: all operands from [23:0]
// RULE17 - lower result a*b or sum; upper c*d
// RULE18 - software matches exponent widths to format
// RULE19 - unassigned bus bits never reach operands
module fls_lane_select
  import fls_pkg::*;
#(
  parameter int RESULT_W = OPND_W
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // apb slave
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [DATA_W-1:0]   pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [DATA_W-1:0]   prdata,
  output logic                     pready,
  output logic                     pslverr,
  // operand buses from fabric
  input  wire logic [BUS_W-1:0]    firstLowBus,
  input  wire logic [BUS_W-1:0]    secondLowBus,
  input  wire logic [BUS_W-1:0]    firstHighBus,
  input  wire logic [BUS_W-1:0]    secondHighBus,
  // selected operands to the multiplication stage
  output logic      [OPND_W-1:0]   operandA,
  output logic      [OPND_W-1:0]   operandB,
  output logic      [OPND_W-1:0]   operandC,
  output logic      [OPND_W-1:0]   operandD,
  output logic      [1:0]          operandFormat,
  output logic                     first_product_exponent_width,
  output logic                     second_product_exponent_width,
  // products back from the arithmetic
  input  wire logic [RESULT_W-1:0] productFirst,
  input  wire logic [RESULT_W-1:0] productSecond,
  input  wire logic [RESULT_W-1:0] productSum,
  // results
  output logic      [RESULT_W-1:0] lowerResult,
  output logic      [RESULT_W-1:0] upperResult
);

  ////////////////////////////////////////////////////////////////////////////
  // layout decode
  fls_cfg_if cfgLink ();

  fls_layout_decode uDecode (
    .cfg (cfgLink.decoder)
  );

  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] ctrl_d;

  assign cfgLink.lowCode  = ctrl_q[CTRL_LOW_LSB +: LOW_CODE_W];
  assign cfgLink.highCode = ctrl_q[CTRL_HIGH_LSB +: HIGH_CODE_W];

  ////////////////////////////////////////////////////////////////////////////
  // lane offsets per layout; d offset unused when d is forced
  logic [OFF_W-1:0] offA;
  logic [OFF_W-1:0] offB;
  logic [OFF_W-1:0] offC;
  logic [OFF_W-1:0] offD;

  always_comb begin
    offA = OFF_0;
    offB = OFF_0;
    offC = OFF_0;
    offD = OFF_0;
    unique case (cfgLink.layout)
      LAY_BF16_SINGLE, LAY_FP16_SINGLE: begin
        offB = OFF_16; // [RULE3] [RULE8]
        offC = OFF_32;
      end
      LAY_BF16_SPLIT, LAY_FP16_SPLIT: begin
        offB = OFF_16; // [RULE4] [RULE9]
        offD = OFF_16;
      end
      LAY_BF16_DUAL, LAY_FP16_DUAL: begin
        offB = OFF_16; // [RULE5] [RULE10]
        offC = OFF_32;
        offD = OFF_48;
      end
      LAY_BF16_ALT, LAY_FP16_ALT: begin
        offC = OFF_16; // [RULE6] [RULE11]
        offD = OFF_16;
      end
      LAY_FP24_SINGLE: begin
        offB = OFF_24; // [RULE13]
        offC = OFF_48;
      end
      LAY_FP24_SPLIT: begin
        offB = OFF_24; // [RULE14]
        offD = OFF_24;
      end
      LAY_FP24_DUAL: begin
        offC = OFF_24; // [RULE15]
        offD = OFF_24;
      end
      LAY_BF16_CMPCT, LAY_FP16_CMPCT, LAY_FP24_CMPCT, LAY_NONE: begin
        offA = OFF_0;  // [RULE7] [RULE12] [RULE16]
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // lane extraction; only the addressed slice is read
  function automatic logic [OPND_W-1:0] pickLane(input logic [BUS_W-1:0] bus,
                                                 input logic [OFF_W-1:0] off,
                                                 input logic             wide);
    logic [OPND_W-1:0] slice;
    slice = '0;
    if (wide) begin
      slice = bus[off +: OPND_W];
    end else begin
      slice = {8'h00, bus[off +: HALF_W]};
    end
    return slice;
  endfunction

  logic [OPND_W-1:0] oneValue;
  logic              laneValid;
  wire  [OPND_W-1:0] laneA = pickLane(firstLowBus, offA, cfgLink.wideLanes);   // [RULE19]
  wire  [OPND_W-1:0] laneB = pickLane(secondLowBus, offB, cfgLink.wideLanes);  // [RULE19]
  wire  [OPND_W-1:0] laneC = pickLane(firstHighBus, offC, cfgLink.wideLanes);  // [RULE19]
  wire  [OPND_W-1:0] laneD = pickLane(secondHighBus, offD, cfgLink.wideLanes); // [RULE19]

  assign laneValid = (cfgLink.layout != LAY_NONE);
  assign oneValue  = (cfgLink.format == FMT_FP24) ? ONE_FP24 :
                     (cfgLink.format == FMT_FP16) ? ONE_FP16 : ONE_BF16;

  // unknown code pairs give zero operands rather than stray bus bits
  wire [OPND_W-1:0] nextA = laneValid ? laneA : '0;
  wire [OPND_W-1:0] nextB = laneValid ? laneB : '0;
  wire [OPND_W-1:0] nextC = laneValid ? laneC : '0;
  wire [OPND_W-1:0] nextD = !laneValid ? '0 :
                            cfgLink.threeOperand ? oneValue : laneD; // [RULE2]

  // a,b go to the first product unit, c,d to the second
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      operandA <= '0;
      operandB <= '0;
      operandC <= '0;
      operandD <= '0;
    end else begin
      operandA <= nextA; // [RULE1]
      operandB <= nextB;
      operandC <= nextC; // [RULE1]
      operandD <= nextD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result selection
  wire sumSelect = ctrl_q[CTRL_SUM_BIT];
  wire [RESULT_W-1:0] nextLower = sumSelect ? productSum : productFirst; // [RULE17]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lowerResult <= '0;
      upperResult <= '0;
    end else begin
      lowerResult <= nextLower;
      upperResult <= productSecond; // [RULE17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // exponent width settings; mismatch flagged, not corrected
  wire expMismatch = laneValid &&
                     ((ctrl_q[CTRL_EXPW1_BIT] != cfgLink.needExp8) ||
                      (ctrl_q[CTRL_EXPW2_BIT] != cfgLink.needExp8)); // [RULE18]

  assign first_product_exponent_width  = ctrl_q[CTRL_EXPW1_BIT];
  assign second_product_exponent_width = ctrl_q[CTRL_EXPW2_BIT];
  assign operandFormat                 = cfgLink.format;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  wire accessPhase = psel && penable;
  wire hitCtrl     = (paddr == REG_CTRL);
  wire hitStatus   = (paddr == REG_STATUS);
  wire hitOpnd     = (paddr == REG_OPND_A) || (paddr == REG_OPND_B)
                   || (paddr == REG_OPND_C) || (paddr == REG_OPND_D);
  wire hitAny      = hitCtrl || hitStatus || hitOpnd;
  wire ctrlWrite   = accessPhase && pwrite && hitCtrl;

  for (genvar lane = 0; lane < 4; lane++) begin : gCtrlBytes
    assign ctrl_d[lane*8 +: 8] = (ctrlWrite && pstrb[lane])
                               ? (pwdata[lane*8 +: 8] & CTRL_USED[lane*8 +: 8])
                               : ctrl_q[lane*8 +: 8];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  logic [DATA_W-1:0] statusWord;
  always_comb begin
    statusWord                              = '0;
    statusWord[STAT_VALID_BIT]              = laneValid;
    statusWord[STAT_THREE_BIT]              = cfgLink.threeOperand;
    statusWord[STAT_MISM_BIT]               = expMismatch;
    statusWord[STAT_FMT_LSB +: 2]           = cfgLink.format;
  end

  wire [DATA_W-1:0] readWord =
    hitCtrl                 ? ctrl_q :
    hitStatus               ? statusWord :
    (paddr == REG_OPND_A)   ? {8'h00, operandA} :
    (paddr == REG_OPND_B)   ? {8'h00, operandB} :
    (paddr == REG_OPND_C)   ? {8'h00, operandC} :
    (paddr == REG_OPND_D)   ? {8'h00, operandD} : '0;

  assign pready  = 1'b1;
  assign pslverr = accessPhase && !hitAny;
  assign prdata  = (accessPhase && !pwrite) ? readWord : '0;

endmodule

// file: test/fls_fabric_model.sv
// fabric-side model: fresh random operand buses and product words on every rising edge
// assumes the bench samples the buses after this model's edge updates
`timescale 1ns/1ps
module fls_fabric_model
  import fls_pkg::*;
#(
  parameter int RESULT_W = OPND_W
) (
  // clock
  input  wire logic                ref_clk,
  // operand buses
  output logic      [BUS_W-1:0]    firstLowBus,
  output logic      [BUS_W-1:0]    secondLowBus,
  output logic      [BUS_W-1:0]    firstHighBus,
  output logic      [BUS_W-1:0]    secondHighBus,
  // arithmetic results
  output logic      [RESULT_W-1:0] productFirst,
  output logic      [RESULT_W-1:0] productSecond,
  output logic      [RESULT_W-1:0] productSum
);
  integer      seed = 32'hEB844D20;
  logic [95:0] r [7];
  ////////////////////////////////////////////////////////////////////////////
  // unused lanes toggle too, so stray bits would reach the operands
  always @(posedge ref_clk) begin
    foreach (r[i]) r[i] = {$random(seed), $random(seed), $random(seed)};
    firstLowBus   <= r[0][BUS_W-1:0];
    secondLowBus  <= r[1][BUS_W-1:0];
    firstHighBus  <= r[2][BUS_W-1:0];
    secondHighBus <= r[3][BUS_W-1:0];
    productFirst  <= r[4][RESULT_W-1:0];
    productSecond <= r[5][RESULT_W-1:0];
    productSum    <= r[6][RESULT_W-1:0];
  end
endmodule

// file: test/fls_lane_select_checker.sv
// checker of the lane select top: lane maps, forced one, result select, apb errors
// assumes ctrl writes carry all byte strobes
`timescale 1ns/1ps
module fls_lane_select_checker
  import fls_pkg::*;
#(
  parameter int RESULT_W = OPND_W
) (
  // clock, reset and apb
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic [ADDR_W-1:0]   paddr,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [DATA_W-1:0]   pwdata,
  input wire logic [DATA_W-1:0]   prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // buses and operands
  input wire logic [BUS_W-1:0]    firstLowBus,
  input wire logic [BUS_W-1:0]    secondLowBus,
  input wire logic [BUS_W-1:0]    firstHighBus,
  input wire logic [BUS_W-1:0]    secondHighBus,
  input wire logic [OPND_W-1:0]   operandA,
  input wire logic [OPND_W-1:0]   operandB,
  input wire logic [OPND_W-1:0]   operandC,
  input wire logic [OPND_W-1:0]   operandD,
  input wire logic                first_product_exponent_width,
  // results
  input wire logic [RESULT_W-1:0] productFirst,
  input wire logic [RESULT_W-1:0] productSum,
  input wire logic [RESULT_W-1:0] productSecond,
  input wire logic [RESULT_W-1:0] lowerResult,
  input wire logic [RESULT_W-1:0] upperResult
);
  // shadow of ctrl rebuilt from apb traffic
  logic [21:0] ctrl_q;
  wire         ctrlWr = psel && penable && pwrite && pready && paddr == REG_CTRL;
  wire  [10:0] code   = {ctrl_q[4:0], ctrl_q[13:8]};
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= '0;
    end else if (ctrlWr) begin
      ctrl_q <= pwdata[21:0] & CTRL_USED[21:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  bf16_single_a: assert property (code == {LO_BF16_SINGLE, HI_BF16_SINGLE} |=>
    operandC == {8'h00, $past(firstHighBus[47:32])} && operandD == ONE_BF16)
    else $error("bf16 single lanes wrong");
  bf16_dual_a: assert property (code == {LO_BF16_DUAL, HI_BF16_DUAL} |=>
    operandD == {8'h00, $past(secondHighBus[63:48])}) else $error("bf16 dual d lane wrong");
  fp16_split_a: assert property (code == {LO_FP16_SINGLE, HI_FP16_SPLIT} |=>
    operandB == {8'h00, $past(secondLowBus[31:16])} && operandD == {8'h00, $past(secondHighBus[31:16])})
    else $error("fp16 split lanes wrong");
  fp24_single_a: assert property (code == {LO_FP24_SINGLE, HI_FP24_SINGLE} |=>
    operandA == $past(firstLowBus[23:0]) && operandC == $past(firstHighBus[71:48]) && operandD == ONE_FP24)
    else $error("fp24 single lanes wrong");
  fp24_cmpct_a: assert property (code == {LO_FP24_DUAL, HI_FP24_CMPCT} |=>
    operandB == $past(secondLowBus[23:0]) && operandD == $past(secondHighBus[23:0]))
    else $error("fp24 compact lanes wrong");
  result_sel_a: assert property (1'b1 |=> upperResult == $past(productSecond) &&
    lowerResult == ($past(ctrl_q[16]) ? $past(productSum) : $past(productFirst)))
    else $error("result select wrong");
  exp_width_a: assert property (first_product_exponent_width == ctrl_q[20])
    else $error("exponent width output wrong");
  unmapped_err_a: assert property (psel && penable && paddr > REG_OPND_D |-> pready && pslverr && prdata == '0)
    else $error("unmapped access not refused");
  cover property (code == {LO_BF16_ALT, HI_BF16_CMPCT});
  cover property (code == {LO_FP16_SINGLE, HI_FP16_SINGLE});
  cover property (psel && penable && pslverr);
endmodule
bind fls_lane_select fls_lane_select_checker #(.RESULT_W(RESULT_W)) u_checker (
  .ref_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
  .firstLowBus, .secondLowBus, .firstHighBus, .secondHighBus, .operandA, .operandB, .operandC,
  .operandD, .first_product_exponent_width, .productFirst, .productSum, .productSecond,
  .lowerResult, .upperResult
);

// file: test/fls_lane_select_tb.sv
// self-checking bench: every layout set over apb, random operands from the fabric model
// assumes nothing of apb wait states; every wait is bounded
`timescale 1ns/1ps
module fls_lane_select_tb
  import fls_pkg::*;
;
  logic                ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0]   paddr = '0;
  logic [DATA_W-1:0]   pwdata = '0;
  logic [3:0]          pstrb = 4'hF;
  logic [DATA_W-1:0]   prdata, rd;
  logic                pready, pslverr, err, first_product_exponent_width, second_product_exponent_width;
  logic [BUS_W-1:0]    firstLowBus, secondLowBus, firstHighBus, secondHighBus;
  logic [OPND_W-1:0]   operandA, operandB, operandC, operandD, lowerResult, upperResult;
  logic [OPND_W-1:0]   productFirst, productSecond, productSum;
  logic [1:0]          operandFormat;
  int                  fails = 0, tests_run = 0, k;
  always #12.5 ref_clk = ~ref_clk;
  fls_lane_select u_dut (
    .ref_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .firstLowBus, .secondLowBus, .firstHighBus, .secondHighBus, .operandA, .operandB, .operandC,
    .operandD, .operandFormat, .first_product_exponent_width, .second_product_exponent_width,
    .productFirst, .productSecond, .productSum, .lowerResult, .upperResult
  );
  fls_fabric_model u_fabric (
    .ref_clk, .firstLowBus, .secondLowBus, .firstHighBus, .secondHighBus,
    .productFirst, .productSecond, .productSum
  );
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [OPND_W-1:0] h(input logic [BUS_W-1:0] b, input int o);
    return {8'h00, b[o +: 16]};
  endfunction
  function automatic logic [OPND_W-1:0] w(input logic [BUS_W-1:0] b, input int o);
    return b[o +: 24];
  endfunction
  // {code, valid, three, format, a, b, c, d} per table entry
  function automatic logic [110:0] expOps(input int k, input logic [BUS_W-1:0] fl, sl, fh, sh);
    case (k)
      0: return {LO_BF16_SINGLE, HI_BF16_SINGLE, 4'hD, h(fl, 0), h(sl, 16), h(fh, 32), ONE_BF16};
      1: return {LO_BF16_SINGLE, HI_BF16_SPLIT, 4'h9, h(fl, 0), h(sl, 16), h(fh, 0), h(sh, 16)};
      2: return {LO_BF16_DUAL, HI_BF16_DUAL, 4'h9, h(fl, 0), h(sl, 16), h(fh, 32), h(sh, 48)};
      3: return {LO_BF16_ALT, HI_BF16_ALT, 4'h9, h(fl, 0), h(sl, 0), h(fh, 16), h(sh, 16)};
      4: return {LO_BF16_ALT, HI_BF16_CMPCT, 4'h9, h(fl, 0), h(sl, 0), h(fh, 0), h(sh, 0)};
      5: return {LO_FP16_SINGLE, HI_FP16_SINGLE, 4'hE, h(fl, 0), h(sl, 16), h(fh, 32), ONE_FP16};
      6: return {LO_FP16_SINGLE, HI_FP16_SPLIT, 4'hA, h(fl, 0), h(sl, 16), h(fh, 0), h(sh, 16)};
      7: return {LO_FP16_DUAL, HI_FP16_DUAL, 4'hA, h(fl, 0), h(sl, 16), h(fh, 32), h(sh, 48)};
      8: return {LO_FP16_ALT, HI_FP16_ALT, 4'hA, h(fl, 0), h(sl, 0), h(fh, 16), h(sh, 16)};
      9: return {LO_FP16_ALT, HI_FP16_CMPCT, 4'hA, h(fl, 0), h(sl, 0), h(fh, 0), h(sh, 0)};
      10: return {LO_FP24_SINGLE, HI_FP24_SINGLE, 4'hF, w(fl, 0), w(sl, 24), w(fh, 48), ONE_FP24};
      11: return {LO_FP24_SINGLE, HI_FP24_SPLIT, 4'hB, w(fl, 0), w(sl, 24), w(fh, 0), w(sh, 24)};
      12: return {LO_FP24_DUAL, HI_FP24_DUAL, 4'hB, w(fl, 0), w(sl, 0), w(fh, 24), w(sh, 24)};
      13: return {LO_FP24_DUAL, HI_FP24_CMPCT, 4'hB, w(fl, 0), w(sl, 0), w(fh, 0), w(sh, 0)};
      14: return {LO_BF16_SINGLE, HI_BF16_DUAL, 100'h0};
      default: return '0;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [95:0] got, input logic [95:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; answer sampled at the edge that ends the access phase
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
    logic rdy = 1'b0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (int i = 0; i < 16 && !rdy; i++) begin
      @(posedge ref_clk);
      rdy = (pready === 1'b1);
      rd = prdata;
      err = pslverr;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!rdy) begin
      fails++;
      conclude();
    end
  endtask
  task automatic runLayout(input int k, input logic sumSel, input logic badExp);
    logic [110:0]      e;
    logic [DATA_W-1:0] word;
    logic [47:0]       prod;
    logic [3:0]        cfgOut;
    logic              exp8;
    e = expOps(k, '0, '0, '0, '0);
    exp8 = (e[97:96] != FMT_FP16);
    word = {10'h000, exp8, exp8 ^ badExp, 3'h0, sumSel, 2'h0, e[105:100], 3'h0, e[110:106]};
    apb(1'b1, REG_CTRL, word);
    apb(1'b0, REG_CTRL, '0);
    check({64'h0, rd}, {64'h0, word & CTRL_USED});
    apb(1'b0, REG_STATUS, '0);
    check({64'h0, rd}, {90'h0, e[97:96], 1'b0, e[99] & badExp, e[98], e[99]});
    cfgOut = {operandFormat, first_product_exponent_width, second_product_exponent_width};
    check({92'h0, cfgOut}, {92'h0, e[97:96], exp8 ^ badExp, exp8});
    repeat (6) begin
      @(posedge ref_clk);
      #1;
      e = expOps(k, firstLowBus, secondLowBus, firstHighBus, secondHighBus);
      prod = {sumSel ? productSum : productFirst, productSecond};
      @(posedge ref_clk);
      #1;
      check({operandA, operandB, operandC, operandD}, e[95:0]);
      check({48'h0, lowerResult, upperResult}, {48'h0, prod});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, REG_CTRL, '0);
    check({64'h0, rd}, {64'h0, CTRL_RESET});
    apb(1'b0, 12'h040, '0);
    check({63'h0, err, rd}, {63'h0, 1'b1, 32'h0});
    apb(1'b1, REG_STATUS, 32'hFFFFFFFF);
    apb(1'b0, REG_STATUS, '0);
    check({64'h0, rd}, 96'h0);
    // two passes: lower result flips between product and sum
    for (k = 0; k < 32; k++) runLayout(k % 16, k[4], k == 2);
    conclude();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    conclude();
  end
endmodule
